/* rtl/ddrpi_regs.vh */
// Constants for the DDR2 pin interface: pin slots, command codes, mode fields.
`ifndef DDRPI_REGS_VH
`define DDRPI_REGS_VH

// Positions of each pin in the synchroniser vector.
`define DDRPI_SYNC_W     35
`define DDRPI_P_CK       0
`define DDRPI_P_CK_N     1
`define DDRPI_P_CKE      2
`define DDRPI_P_CS_N     3
`define DDRPI_P_RAS_N    4
`define DDRPI_P_CAS_N    5
`define DDRPI_P_WE_N     6
`define DDRPI_P_ODT      7
`define DDRPI_P_BA_LO    8
`define DDRPI_P_BA_HI    10
`define DDRPI_P_AD_LO    11
`define DDRPI_P_AD_HI    24
`define DDRPI_P_DQ_LO    25
`define DDRPI_P_DQ_HI    32
`define DDRPI_P_DQS      33
`define DDRPI_P_DM       34

// Command codes on {RAS_N, CAS_N, WE_N} while chip select is low.
`define DDRPI_CMD_MRS    3'h0
`define DDRPI_CMD_REF    3'h1
`define DDRPI_CMD_PRE    3'h2
`define DDRPI_CMD_ACT    3'h3
`define DDRPI_CMD_WR     3'h4
`define DDRPI_CMD_RD     3'h5
`define DDRPI_CMD_NOP    3'h7

// Mode register fields on the address pins.
`define DDRPI_MR_BL_LO   0
`define DDRPI_MR_BL_HI   2
`define DDRPI_MR_CL_LO   4
`define DDRPI_MR_CL_HI   6
`define DDRPI_A_AP       10
`define DDRPI_EMR_RDQS   11
`define DDRPI_BL4_CODE   3'h2
`define DDRPI_BL8_CODE   3'h3
`define DDRPI_BA_MR      3'h0
`define DDRPI_BA_EMR1    3'h1

// Reset values of the mode fields.
`define DDRPI_RST_BL     3'h2
`define DDRPI_RST_CL     3'h3

// Power states.
`define DDRPI_ST_ACT     2'h0
`define DDRPI_ST_PPD     2'h1
`define DDRPI_ST_APD     2'h2
`define DDRPI_ST_SREF    2'h3

`endif

/* rtl/ddrpi_top.v */
// DDR2 device pin interface: sampling, clock enable, masking and strobes.
`timescale 1ns/1ps
`include "ddrpi_regs.vh"

// How it works
// - Address and control are taken where CK rises and CK_N falls.
// - Read beats are driven on both directions of the clock crossing.
// - High CKE runs clocks, input buffers and drivers; low CKE stops them.
// - CKE low enters self refresh or precharge or active power-down.
// - CKE is sampled at crossings for power-down entry, exit, refresh entry.
// - Self refresh exit follows CKE going high without any clock edge.
// - Power-down leaves only clock, termination enable and CKE buffers on.
// - Self refresh leaves only the CKE buffer on.
// - Commands taken with chip select high are ignored.
// - Commands decode from chip select, row, column strobe and write enable.
// - Registered termination enable switches termination on data-side pins.
// - Write beats sampled with mask high are discarded.
// - The mask is sampled on both strobe edges with each beat.
// - An extended mode bit selects data mask or read strobe on x8.
// - Enabled read strobe mirrors the data strobe and disables masking.
module DDRPI_top (
  input  wire        CLK_SYS,
  input  wire        RST_N,
  input  wire        CK,
  input  wire        CK_N,
  input  wire        CKE,
  input  wire        CS_N,
  input  wire        RAS_N,
  input  wire        CAS_N,
  input  wire        WE_N,
  input  wire        ODT,
  input  wire [2:0]  BA,
  input  wire [13:0] ADDR,
  input  wire [7:0]  DQ_I,
  output reg  [7:0]  DQ_O,
  output reg         DQ_OE,
  input  wire        DQS_I,
  output reg         DQS_O,
  output reg         DQS_N_O,
  output reg         DQS_OE,
  input  wire        DM_I,
  output reg         RDQS_O,
  output reg         RDQS_N_O,
  output reg         RDQS_OE,
  output reg         TERM_EN,
  output reg         CLK_RUN,
  output reg         CMD_BUF_EN,
  output reg         CK_BUF_EN,
  output reg         ODT_BUF_EN,
  output reg  [1:0]  PWR_STATE,
  output reg         CMD_STB,
  output reg  [2:0]  CMD_CODE,
  output reg  [2:0]  CMD_BA,
  output reg  [13:0] CMD_ADDR,
  output reg         RD_BEAT,
  input  wire [7:0]  RD_DATA,
  output reg         WR_STB,
  output reg  [7:0]  WR_DATA,
  output reg  [2:0]  WR_BEAT
);

  // ------------------------------------------------------------------
  // Burst length decode
  // ------------------------------------------------------------------
  function [3:0] bl_of;
    input [2:0] code;
    begin
      bl_of = (code == `DDRPI_BL8_CODE) ? 4'h8 : 4'h4;
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  wire [`DDRPI_SYNC_W-1:0] pin_in = {DM_I, DQS_I, DQ_I, ADDR, BA, ODT,
                                     WE_N, CAS_N, RAS_N, CS_N, CKE,
                                     CK_N, CK};
  reg  [`DDRPI_SYNC_W-1:0] sync1;
  reg  [`DDRPI_SYNC_W-1:0] sync2;
  reg  [`DDRPI_SYNC_W-1:0] sync3;
  reg  [`DDRPI_SYNC_W-1:0] flt;
  integer i;

  // A bit takes its new value once the second and third stages agree.
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sync1 <= {`DDRPI_SYNC_W{1'b0}};
      sync2 <= {`DDRPI_SYNC_W{1'b0}};
      sync3 <= {`DDRPI_SYNC_W{1'b0}};
      flt   <= {`DDRPI_SYNC_W{1'b0}};
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (i = 0; i < `DDRPI_SYNC_W; i = i + 1) begin
        if (sync2[i] == sync3[i]) begin
          flt[i] <= sync3[i];
        end
      end
    end
  end
  wire       cke_f  = flt[`DDRPI_P_CKE];
  wire       cs_n_f = flt[`DDRPI_P_CS_N];
  wire [2:0] cmd_f  = {flt[`DDRPI_P_RAS_N], flt[`DDRPI_P_CAS_N],
                       flt[`DDRPI_P_WE_N]};
  wire [2:0]  ba_f  = flt[`DDRPI_P_BA_HI:`DDRPI_P_BA_LO];
  wire [13:0] ad_f  = flt[`DDRPI_P_AD_HI:`DDRPI_P_AD_LO];
  wire [7:0]  dq_f  = flt[`DDRPI_P_DQ_HI:`DDRPI_P_DQ_LO];
  wire        dqs_f = flt[`DDRPI_P_DQS];
  wire        dm_f  = flt[`DDRPI_P_DM];

  // ------------------------------------------------------------------
  // Clock crossing detection
  // ------------------------------------------------------------------
  reg  xing_q;
  reg  dqs_q;
  wire xing     = flt[`DDRPI_P_CK] & ~flt[`DDRPI_P_CK_N];
  wire ck_rise  = xing & ~xing_q & CK_BUF_EN;
  wire ck_any   = (xing ^ xing_q) & CK_BUF_EN;
  wire dqs_edge = (dqs_f ^ dqs_q) & ~DQS_OE & CMD_BUF_EN;

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      xing_q <= 1'b0;
      dqs_q  <= 1'b0;
    end else begin
      xing_q <= xing;
      dqs_q  <= dqs_f;
    end
  end

  // ------------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------------
  localparam [1:0] ST_ACT  = `DDRPI_ST_ACT;
  localparam [1:0] ST_PPD  = `DDRPI_ST_PPD;
  localparam [1:0] ST_APD  = `DDRPI_ST_APD;
  localparam [1:0] ST_SREF = `DDRPI_ST_SREF;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [7:0] bank_open;
  reg        cke_prev;
  wire       cmd_take = ck_rise & ~cs_n_f & (state == ST_ACT)
                        & cke_prev;
  always @* begin
    next_state = state;
    case (state)
      ST_ACT: begin
        if (ck_rise && !cke_f) begin
          if (!cs_n_f && cmd_f == `DDRPI_CMD_REF) begin
            next_state = ST_SREF;
          end else if (|bank_open) begin
            next_state = ST_APD;
          end else begin
            next_state = ST_PPD;
          end
        end
      end
      ST_PPD, ST_APD: begin
        if (ck_rise && cke_f) begin
          next_state = ST_ACT;
        end
      end
      ST_SREF: begin
        if (cke_f) begin
          next_state = ST_ACT;
        end
      end
      default: next_state = ST_ACT;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state      <= ST_ACT;
      cke_prev   <= 1'b0;
      PWR_STATE  <= ST_ACT;
      CLK_RUN    <= 1'b0;
      CMD_BUF_EN <= 1'b0;
      CK_BUF_EN  <= 1'b0;
      ODT_BUF_EN <= 1'b0;
    end else begin
      state     <= next_state;
      PWR_STATE <= next_state;
      if (ck_rise || next_state == ST_SREF) begin
        cke_prev <= cke_f & (next_state == ST_ACT);
      end
      CLK_RUN    <= (next_state == ST_ACT);
      CMD_BUF_EN <= (next_state == ST_ACT);
      CK_BUF_EN  <= (next_state != ST_SREF);
      ODT_BUF_EN <= (next_state != ST_SREF);
    end
  end

  // ------------------------------------------------------------------
  // Command decode, mode settings and bank tracking
  // ------------------------------------------------------------------
  reg [2:0] mr_bl;
  reg [2:0] mr_cl;
  reg       rdqs_en;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      CMD_STB   <= 1'b0;
      CMD_CODE  <= `DDRPI_CMD_NOP;
      CMD_BA    <= 3'h0;
      CMD_ADDR  <= 14'h0000;
      mr_bl     <= `DDRPI_RST_BL;
      mr_cl     <= `DDRPI_RST_CL;
      rdqs_en   <= 1'b0;
      bank_open <= 8'h00;
      TERM_EN   <= 1'b0;
    end else begin
      CMD_STB <= cmd_take & (cmd_f != `DDRPI_CMD_NOP);
      if (cmd_take) begin
        CMD_CODE <= cmd_f;
        CMD_BA   <= ba_f;
        CMD_ADDR <= ad_f;
        case (cmd_f)
          `DDRPI_CMD_MRS: begin
            if (ba_f == `DDRPI_BA_MR) begin
              mr_bl <= ad_f[`DDRPI_MR_BL_HI:`DDRPI_MR_BL_LO];
              mr_cl <= ad_f[`DDRPI_MR_CL_HI:`DDRPI_MR_CL_LO];
            end else if (ba_f == `DDRPI_BA_EMR1) begin
              rdqs_en <= ad_f[`DDRPI_EMR_RDQS];
            end
          end
          `DDRPI_CMD_ACT: begin
            bank_open[ba_f] <= 1'b1;
          end
          `DDRPI_CMD_PRE: begin
            if (ad_f[`DDRPI_A_AP]) begin
              bank_open <= 8'h00;
            end else begin
              bank_open[ba_f] <= 1'b0;
            end
          end
          `DDRPI_CMD_WR, `DDRPI_CMD_RD: begin
            if (ad_f[`DDRPI_A_AP]) begin
              bank_open[ba_f] <= 1'b0;
            end
          end
          default: bank_open <= bank_open;
        endcase
      end
      // Termination follows the value registered at each rising crossing.
      TERM_EN <= ODT_BUF_EN
                 & (ck_rise ? flt[`DDRPI_P_ODT] : TERM_EN);
    end
  end

  // ------------------------------------------------------------------
  // Write beats
  // ------------------------------------------------------------------
  reg [3:0] wr_left;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wr_left <= 4'h0;
      WR_STB  <= 1'b0;
      WR_DATA <= 8'h00;
      WR_BEAT <= 3'h0;
    end else begin
      WR_STB <= 1'b0;
      if (cmd_take && cmd_f == `DDRPI_CMD_WR) begin
        wr_left <= bl_of(mr_bl);
        WR_BEAT <= 3'h7;
      end else if (dqs_edge && wr_left != 4'h0) begin
        wr_left <= wr_left - 4'h1;
        WR_BEAT <= WR_BEAT + 3'h1;
        WR_DATA <= dq_f;
        WR_STB  <= ~(dm_f & ~rdqs_en);
      end
    end
  end

  // ------------------------------------------------------------------
  // Read beats and strobes
  // ------------------------------------------------------------------
  reg [2:0] rd_wait;
  reg [3:0] rd_left;
  reg       rd_arm;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rd_wait  <= 3'h0;
      rd_left  <= 4'h0;
      rd_arm   <= 1'b0;
      RD_BEAT  <= 1'b0;
      DQ_O     <= 8'h00;
      DQ_OE    <= 1'b0;
      DQS_O    <= 1'b0;
      DQS_N_O  <= 1'b1;
      DQS_OE   <= 1'b0;
      RDQS_O   <= 1'b0;
      RDQS_N_O <= 1'b1;
      RDQS_OE  <= 1'b0;
    end else begin
      RD_BEAT <= 1'b0;
      if (!CLK_RUN) begin
        rd_arm   <= 1'b0;
        rd_left  <= 4'h0;
        DQ_OE    <= 1'b0;
        DQS_OE   <= 1'b0;
        RDQS_OE  <= 1'b0;
      end else if (cmd_take && cmd_f == `DDRPI_CMD_RD) begin
        rd_wait <= mr_cl;
        rd_arm  <= 1'b1;
      end else if (rd_arm && ck_rise) begin
        if (rd_wait <= 3'h1) begin
          rd_arm   <= 1'b0;
          rd_left  <= bl_of(mr_bl);
          DQS_O    <= 1'b0;
          DQS_N_O  <= 1'b1;
          DQS_OE   <= 1'b1;
          RDQS_O   <= 1'b0;
          RDQS_N_O <= 1'b1;
          RDQS_OE  <= rdqs_en;
        end else begin
          rd_wait <= rd_wait - 3'h1;
        end
      end else if (ck_any && rd_left != 4'h0) begin
        rd_left  <= rd_left - 4'h1;
        RD_BEAT  <= 1'b1;
        DQ_O     <= RD_DATA;
        DQ_OE    <= 1'b1;
        DQS_O    <= ~DQS_O;
        DQS_N_O  <= DQS_O;
        RDQS_O   <= ~DQS_O;
        RDQS_N_O <= DQS_O;
      end else if (ck_any && DQS_OE) begin
        DQ_OE   <= 1'b0;
        DQS_OE  <= 1'b0;
        RDQS_OE <= 1'b0;
      end
    end
  end

endmodule

/* test/ddrpi_asserts.sv */
// Concurrent checks on the DDR2 pin interface outputs.
`timescale 1ns/1ps
module DDRPI_asserts (
  input wire       CLK_SYS,
  input wire       RST_N,
  input wire       CKE,
  input wire       CS_N,
  input wire [1:0] PWR_STATE,
  input wire       CLK_RUN,
  input wire       CMD_BUF_EN,
  input wire       CK_BUF_EN,
  input wire       ODT_BUF_EN,
  input wire       TERM_EN,
  input wire       CMD_STB,
  input wire       DQS_O,
  input wire       DQS_N_O,
  input wire       RDQS_O,
  input wire       RDQS_N_O,
  input wire       RDQS_OE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_sref_bufs: assert property (PWR_STATE == 2'h3 |->
    !CK_BUF_EN && !ODT_BUF_EN) else $error("buffers on in self refresh");
  a_pd_bufs: assert property (PWR_STATE inside {2'h1, 2'h2} |->
    CK_BUF_EN && ODT_BUF_EN && !CMD_BUF_EN && !CLK_RUN)
    else $error("wrong buffers in power-down");
  a_sref_term: assert property ((PWR_STATE == 2'h3) [*3] |->
    !TERM_EN) else $error("termination on in self refresh");
  a_pd_entry: assert property ($changed(PWR_STATE) &&
    PWR_STATE != 2'h0 |-> !CKE) else $error("low power without low CKE");
  a_sref_exit: assert property ((PWR_STATE == 2'h3 && CKE) [*4] |->
    ##[1:8] PWR_STATE == 2'h0) else $error("self refresh exit late");
  a_stb_pulse: assert property (CMD_STB |=> !CMD_STB)
    else $error("command strobe too long");
  a_stb_sel: assert property (CMD_STB |-> !$past(CS_N, 5))
    else $error("command taken while deselected");
  a_rdqs_copy: assert property (RDQS_OE |-> RDQS_O == DQS_O)
    else $error("read strobe differs from data strobe");
  a_strobe_pair: assert property (DQS_N_O == !DQS_O &&
    RDQS_N_O == !RDQS_O) else $error("strobe pair not complementary");
endmodule

bind DDRPI_top DDRPI_asserts chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CKE(CKE), .CS_N(CS_N),
  .PWR_STATE(PWR_STATE), .CLK_RUN(CLK_RUN), .CMD_BUF_EN(CMD_BUF_EN),
  .CK_BUF_EN(CK_BUF_EN), .ODT_BUF_EN(ODT_BUF_EN), .TERM_EN(TERM_EN),
  .CMD_STB(CMD_STB), .DQS_O(DQS_O), .DQS_N_O(DQS_N_O), .RDQS_O(RDQS_O),
  .RDQS_N_O(RDQS_N_O), .RDQS_OE(RDQS_OE)
);

/* test/ddrpi_ctrl.sv */
// Controller model driving the device's clock, command and write pins.
`timescale 1ns/1ps
module DDRPI_ctrl (
  input  wire        clk_sys,
  output reg         ck,
  output wire        ck_n,
  output reg         cke,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg         odt,
  output reg  [2:0]  ba,
  output reg  [13:0] addr,
  output reg  [7:0]  dq_i,
  output reg         dqs_i,
  output reg         dm_i
);
  reg       ck_on;
  reg [1:0] div;

  assign ck_n = ~ck;

  initial begin
    {ck, cke, cs_n, ras_n, cas_n, we_n, odt, dqs_i, dm_i} = 9'h0F8;
    {ba, addr, dq_i} = 25'h0000000;
    ck_on = 1'b1;
    div = 2'h0;
  end

  // The memory clock runs at one eighth of the system clock.
  always @(negedge clk_sys) begin
    if (ck_on) begin
      div <= div + 2'h1;
      if (div == 2'h3)
        ck <= ~ck;
    end
  end

  // Set up at a clock fall and held one full period, then deselected.
  task cmd(input [3:0] c, input [2:0] b, input [13:0] a, input k, input o);
    begin
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      cke = k;
      odt = o;
      @(negedge ck);
      cs_n = 1'b1;
      ba = ~b;
      addr = ~a;
    end
  endtask

  // Data and mask settle before the strobe toggles and stay after it.
  task wbeat(input [7:0] d, input m);
    begin
      dq_i = d;
      dm_i = m;
      repeat (3) @(negedge clk_sys);
      dqs_i = ~dqs_i;
      repeat (8) @(negedge clk_sys);
      dq_i = ~d;
      @(negedge clk_sys);
    end
  endtask
endmodule

/* test/ddrpi_top_tb.sv */
// Self-checking bench for the DDR2 device pin interface.
`timescale 1ns/1ps
module DDRPI_top_tb;
  reg         clk = 1'b0;
  reg         rst_n;
  reg  [7:0]  rd_data;
  reg  [7:0]  exp_rd;
  reg  [7:0]  exp_wr;
  reg  [2:0]  exp_wb;
  integer     failures;
  integer     cmp_count;
  integer     n_cmd;
  integer     n_wr;
  integer     n_rd;
  integer     n_rq;
  integer     base;
  integer     i;
  wire        ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs_i, dm_i;
  wire [2:0]  ba, cmd_ba, wr_beat, cmd_code;
  wire [13:0] addr, cmd_addr;
  wire [7:0]  dq_i, dq_o, dq_w, wr_data;
  wire [1:0]  pwr_state;
  wire        dq_oe, dqs_o, dqs_oe, rdqs_o, rdqs_oe, term_en, clk_run;
  wire        cmd_buf_en, ck_buf_en, odt_buf_en, cmd_stb, rd_beat, wr_stb;

  // Shared pins carry whichever side is driving.
  assign dq_w = dq_oe ? dq_o : dq_i;

  DDRPI_ctrl u_ctl (
    .clk_sys(clk), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba),
    .addr(addr), .dq_i(dq_i), .dqs_i(dqs_i), .dm_i(dm_i)
  );

  DDRPI_top dut (
    .CLK_SYS(clk), .RST_N(rst_n), .CK(ck), .CK_N(ck_n), .CKE(cke),
    .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .ODT(odt),
    .BA(ba), .ADDR(addr), .DQ_I(dq_w), .DQ_O(dq_o), .DQ_OE(dq_oe),
    .DQS_I(dqs_oe ? dqs_o : dqs_i), .DQS_O(dqs_o), .DQS_N_O(),
    .DQS_OE(dqs_oe), .DM_I(rdqs_oe ? rdqs_o : dm_i), .RDQS_O(rdqs_o),
    .RDQS_N_O(), .RDQS_OE(rdqs_oe), .TERM_EN(term_en), .CLK_RUN(clk_run),
    .CMD_BUF_EN(cmd_buf_en), .CK_BUF_EN(ck_buf_en),
    .ODT_BUF_EN(odt_buf_en), .PWR_STATE(pwr_state), .CMD_STB(cmd_stb),
    .CMD_CODE(cmd_code), .CMD_BA(cmd_ba), .CMD_ADDR(cmd_addr),
    .RD_BEAT(rd_beat), .RD_DATA(rd_data), .WR_STB(wr_stb),
    .WR_DATA(wr_data), .WR_BEAT(wr_beat)
  );

  always #12.5 clk = ~clk;

  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask

  task test_done;
    begin
      if (failures == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Tallies strobes and judges every read and write beat.
  always @(negedge clk) begin
    n_cmd <= n_cmd + cmd_stb;
    n_wr <= n_wr + wr_stb;
    n_rd <= n_rd + rd_beat;
    n_rq <= n_rq + rdqs_oe;
    if (rd_beat === 1'b1) begin
      check(dq_o, exp_rd);
      exp_rd = exp_rd + 8'h11;
      rd_data <= rd_data + 8'h11;
    end
    if (wr_stb === 1'b1) begin
      check(wr_data, exp_wr);
      check(wr_beat, exp_wb);
    end
  end

  task issue(input [3:0] c, input [2:0] b, input [13:0] a, input k, input o);
    begin
      u_ctl.cmd(c, b, a, k, o);
      repeat (4) @(negedge clk);
    end
  endtask

  task t_reset;
    begin
      check({pwr_state, dq_oe, cmd_stb}, 4'h0);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      check({clk_run, ck_buf_en, odt_buf_en}, 3'h7);
    end
  endtask

  task t_decode;
    reg [2:0]  b;
    reg [13:0] a;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        b = (i == 0) ? 3'h0 : 3'h3 + i[2:0];
        a = 14'h0032 + i[13:0];
        base = n_cmd;
        issue({1'b0, i[2:0]}, b, a, 1'b1, 1'b0);
        check(n_cmd - base, 1);
        check({cmd_code, cmd_ba, cmd_addr}, {i[2:0], b, a});
      end
    end
  endtask

  task t_select;
    begin
      base = n_cmd;
      issue(4'hD, 3'h1, 14'h0000, 1'b1, 1'b0);
      check(cmd_code, 3'h3);
      issue(4'h7, 3'h1, 14'h0000, 1'b1, 1'b0);
      check(n_cmd - base, 0);
      check(cmd_code, 3'h7);
    end
  endtask

  task t_write(input m_all, input [2:0] n_exp);
    begin
      base = n_wr;
      issue(4'h4, 3'h6, 14'h0000, 1'b1, 1'b0);
      for (i = 0; i < 5; i = i + 1) begin
        exp_wr = 8'h10 + i[7:0];
        exp_wb = i[2:0];
        u_ctl.wbeat(exp_wr, m_all | (i == 1));
      end
      check(n_wr - base, n_exp);
    end
  endtask

  task t_read(input rdqs, input [3:0] n_b);
    begin
      base = n_rd;
      i = n_rq;
      issue(4'h5, 3'h6, 14'h0000, 1'b1, 1'b0);
      repeat (56) @(negedge clk);
      check(n_rd - base, n_b);
      check({dq_oe, n_rq != i}, {1'b0, rdqs});
    end
  endtask

  task t_odt;
    begin
      issue(4'hF, 3'h0, 14'h0000, 1'b1, 1'b1);
      check(term_en, 1'b1);
      issue(4'hF, 3'h0, 14'h0000, 1'b1, 1'b0);
      check(term_en, 1'b0);
    end
  endtask

  task t_rdqs;
    begin
      issue(4'h0, 3'h1, 14'h0800, 1'b1, 1'b0);
      t_read(1'b1, 4'h4);
      t_write(1'b1, 3'h4);
    end
  endtask

  // Eight-beat bursts with a shorter latency.
  task t_bl8;
    begin
      issue(4'h0, 3'h0, 14'h0023, 1'b1, 1'b0);
      t_read(1'b1, 4'h8);
    end
  endtask

  task t_pdown(input [3:0] c, input [1:0] st);
    begin
      issue(c, 3'h2, 14'h0400, 1'b1, 1'b0);
      issue(4'hF, 3'h0, 14'h0000, 1'b0, 1'b0);
      check(pwr_state, st);
      check({clk_run, cmd_buf_en, ck_buf_en, odt_buf_en}, 4'h3);
      base = n_cmd;
      issue(4'h3, 3'h1, 14'h0000, 1'b0, 1'b0);
      check(n_cmd - base, 0);
      issue(4'hF, 3'h0, 14'h0000, 1'b1, 1'b0);
      check(pwr_state, 2'h0);
    end
  endtask

  task t_sref;
    begin
      issue(4'h2, 3'h0, 14'h0400, 1'b1, 1'b0);
      issue(4'h1, 3'h0, 14'h0000, 1'b0, 1'b1);
      check(pwr_state, 2'h3);
      check({ck_buf_en, odt_buf_en, term_en}, 3'h0);
      u_ctl.ck_on = 1'b0;
      repeat (16) @(negedge clk);
      u_ctl.cke = 1'b1;
      repeat (8) @(negedge clk);
      check({pwr_state, clk_run}, 3'h1);
      u_ctl.ck_on = 1'b1;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    rd_data = 8'h3C;
    exp_rd = 8'h3C;
    exp_wr = 8'h00;
    exp_wb = 3'h0;
    {failures, cmp_count, n_cmd, n_wr, n_rd, n_rq} = 192'h0;
    repeat (12) @(negedge clk);
    t_reset;
    t_decode;
    t_select;
    t_write(1'b0, 3'h3);
    t_read(1'b0, 4'h4);
    t_odt;
    t_rdqs;
    t_bl8;
    t_pdown(4'h2, 2'h1);
    t_pdown(4'h3, 2'h2);
    t_sref;
    test_done;
  end

  initial begin
    #200000;
    failures = failures + 1;
    test_done;
  end
endmodule
